//--- include/pmc_pkg.sv
// pmc_pkg: register map, field positions, reset values, mode codes and
// start-up timing for the power mode and clock gating controller.
// assumes a 10 MHz bus clock and byte-addressed classic wishbone access.
package pmc_pkg;
    // bus clock period in ns (10 MHz)
    localparam int unsigned CLK_PERIOD_NS = 100;

    // register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_PDIS = 8'h0c;
    localparam logic [7:0] OFS_WAKE_EN = 8'h10;
    localparam logic [7:0] OFS_WAKE_FLG = 8'h14;

    // configuration register field positions
    localparam int unsigned CFG_SRC_LSB = 0;
    localparam int unsigned CFG_POST_BIT = 2;
    localparam int unsigned CFG_PBDIV_LSB = 4;
    localparam int unsigned CFG_SLEEP_BIT = 8;
    localparam int unsigned CFG_STARTUP_BIT = 9;
    localparam int unsigned CFG_FAILMON_BIT = 10;
    localparam int unsigned CFG_BROWNOUT_BIT = 11;
    localparam int unsigned CFG_SECKEEP_BIT = 12;
    // command register bits (write-only strobes)
    localparam int unsigned CMD_WAIT_BIT = 0;
    localparam int unsigned CMD_WDCLR_BIT = 1;
    // status register field positions
    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_SRC_LSB = 4;

    // oscillator source codes, also the index into the oscillator enables
    localparam logic [1:0] SRC_PRIMARY = 2'h0;
    localparam logic [1:0] SRC_FAST_RC = 2'h1;
    localparam logic [1:0] SRC_LOW_POWER_RC = 2'h2;
    localparam logic [1:0] SRC_SECONDARY = 2'h3;

    // reset values of the software-written fields
    localparam logic [1:0] SRC_RST = 2'h1;
    localparam logic [1:0] PBDIV_RST = 2'h0;
    localparam logic BIT_RST = 1'b0;

    // oscillator start-up times after sleep, in ns
    localparam int unsigned T_START_PRI_NS = 1_000_000;
    localparam int unsigned T_START_FRC_NS = 10_000;
    localparam int unsigned T_START_LOW_POWER_RC_OSCILLATOR_NS = 100_000;
    localparam int unsigned T_START_SEC_NS = 2_000_000;
    // least times, rounded up to whole clock cycles
    localparam int unsigned N_START_PRI = (T_START_PRI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned N_START_FRC = (T_START_FRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned N_START_LOW_POWER_RC_OSCILLATOR = (T_START_LOW_POWER_RC_OSCILLATOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned N_START_SEC = (T_START_SEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // operating modes, one-hot
    typedef enum logic [3:0]
    {
        MODE_RUN = 4'b0001,
        MODE_IDLE = 4'b0010,
        MODE_SLEEP = 4'b0100,
        MODE_WAKE = 4'b1000
    } pmc_mode_t;
endpackage

//--- include/pmc_pb_if.sv
// pmc_pb_if: control and tick between the mode controller and the
// peripheral bus clock divider; both ends share clk_i.
`timescale 1ns/100ps
interface pmc_pb_if;
    logic [1:0] ratio; // divide by 2**ratio
    logic run; // low stops the peripheral bus clock
    logic tick; // one pulse per peripheral bus clock period
    modport ctl (output ratio, output run, input tick);
    modport gen (input ratio, input run, output tick);
endinterface

//--- hw/pmc_pbdiv.sv
// pmc_pbdiv: peripheral bus clock divider, emits one tick every 2**ratio
// system clocks while run is high. assumes ratio is changed only rarely.
`timescale 1ns/100ps
module pmc_pbdiv
    import pmc_pkg::*;
#(
    parameter int unsigned CW = 3 // counter width, covers ratio up to 3
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    pmc_pb_if.gen pb
);
    // all state of the divider
    typedef struct packed
    {
        logic [CW-1:0] cnt; // position within the divided period
        logic tick; // registered tick
    } pmc_div_t;

    pmc_div_t div_reg;
    pmc_div_t div_next;
    logic [CW-1:0] limit; // last count of one period

    // next-state: free count, wraps at the programmed fraction
    always_comb
    begin
        div_next = div_reg;
        limit = CW'((1 << pb.ratio) - 1);
        if (!pb.run || div_reg.cnt >= limit)
        begin
            div_next.cnt = '0; // restart so a new ratio takes effect cleanly
        end
        else
        begin
            div_next.cnt = div_reg.cnt + 1'b1;
        end
        div_next.tick = pb.run && (div_next.cnt == '0);
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_reg <= '0;
        end
        else
        begin
            div_reg <= div_next;
        end
    end

    assign pb.tick = div_reg.tick;
endmodule

//--- hw/pmc_top.sv
// pmc_top: power mode controller with cpu and system clock gating,
// oscillator enables, peripheral clock gating and sleep wake-up.
// assumes a classic wishbone master and a cpu that pulses wait_i for
// its wait instruction; wake sources arrive synchronous to clk_i.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/100ps

module pmc_top
    import pmc_pkg::*;
#(
    parameter int unsigned NP = 8, // gated peripheral clocks
    parameter int unsigned NW = 8, // wake sources
    parameter logic [NP-1:0] SLEEP_KEEP = 8'h0f, // peripherals on own clocks
    parameter int unsigned START_PRI = N_START_PRI,
    parameter int unsigned START_FRC = N_START_FRC,
    parameter int unsigned START_LOW_POWER_RC_OSCILLATOR = N_START_LOW_POWER_RC_OSCILLATOR,
    parameter int unsigned START_SEC = N_START_SEC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic wait_i,
    input wire logic [NW-1:0] wake_i,
    output logic cpu_clk_en_o,
    output logic [3:0] osc_en_o,
    output logic [1:0] system_clock_src_o,
    output logic fast_rc_oscillator_post_o,
    output logic peripheral_bus_clock_tick_o,
    output logic [NP-1:0] periph_clk_en_o,
    output logic clock_failure_monitor_en_o,
    output logic brownout_reset_circuit_en_o,
    output logic watchdog_timer_clear_o,
    output logic pin_hold_o,
    output logic idle_o,
    output logic sleep_o
);
    // all state of the controller in one word
    typedef struct packed
    {
        pmc_mode_t mode; // operating mode
        logic [1:0] src; // selected system clock source
        logic post; // fast rc postscaler in use
        logic [1:0] pbdiv; // peripheral bus divide code
        logic sleep_sel; // wait enters sleep when set, idle when clear
        logic startup; // insert start-up delay on wake from sleep
        logic failmon; // clock failure monitor wanted
        logic brownout; // brownout circuit wanted
        logic seckeep; // keep secondary oscillator alive in sleep
        logic [NP-1:0] pdis; // per-peripheral disables
        logic [NW-1:0] wake_en; // wake source mask
        logic [NW-1:0] wake_flg; // sticky wake causes
        logic [15:0] cnt; // start-up delay countdown
        logic ack; // wishbone acknowledge
        logic [31:0] dat; // wishbone read data
        logic cpu_en; // registered outputs follow
        logic [3:0] osc;
        logic [NP-1:0] pclk;
        logic fmon;
        logic wdclr;
        logic hold;
    } pmc_regs_t;

    pmc_regs_t st_reg;
    pmc_regs_t st_next;
    pmc_pb_if pb ();

    logic req; // a wishbone request is pending
    logic wr; // write takes effect at this edge
    logic [31:0] wmask; // byte lanes of the write
    logic wait_req; // cpu or software asked for a low power mode
    logic wake_hit; // an enabled wake source fired
    logic src_off; // selected source may stop in sleep

    // expand wishbone byte selects into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // merge a masked write into a narrow field
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [31:0] m);
        return (old & ~m) | (val & m);
    endfunction

    // start-up delay of each source, counts above 65535 are truncated to 16 bits
    function automatic logic [15:0] start_cycles(input logic [1:0] src);
        logic [15:0] c;
        c = 16'(START_FRC);
        unique case (src)
            SRC_PRIMARY: c = 16'(START_PRI);
            SRC_FAST_RC: c = 16'(START_FRC);
            SRC_LOW_POWER_RC: c = 16'(START_LOW_POWER_RC_OSCILLATOR);
            SRC_SECONDARY: c = 16'(START_SEC);
        endcase
        return c;
    endfunction

    // bus decode: ack one cycle after the request, write at the ack edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & st_reg.ack;
    assign wmask = lane_mask(wb_sel_i);
    assign wait_req = wait_i | (wr && wb_adr_i == OFS_CMD && wmask[CMD_WAIT_BIT]
                                && wb_dat_i[CMD_WAIT_BIT]);
    assign wake_hit = |(wake_i & st_reg.wake_en);
    // low-power rc and a kept secondary feed sleep-alive peripherals
    assign src_off = !(st_reg.src == SRC_LOW_POWER_RC
                       || (st_reg.src == SRC_SECONDARY && st_reg.seckeep));

    // next-state logic: registers, mode sequencing and output decode
    always_comb
    begin
        logic [31:0] cfg;
        logic [31:0] tmp;
        cfg = '0;
        tmp = '0;
        st_next = st_reg;
        st_next.ack = req & ~st_reg.ack;
        st_next.wdclr = 1'b0;

        // register writes
        if (wr)
        begin
            unique case (wb_adr_i)
                OFS_CFG:
                begin
                    cfg[CFG_SRC_LSB +: 2] = st_reg.src;
                    cfg[CFG_POST_BIT] = st_reg.post;
                    cfg[CFG_PBDIV_LSB +: 2] = st_reg.pbdiv;
                    cfg[CFG_SLEEP_BIT] = st_reg.sleep_sel;
                    cfg[CFG_STARTUP_BIT] = st_reg.startup;
                    cfg[CFG_FAILMON_BIT] = st_reg.failmon;
                    cfg[CFG_BROWNOUT_BIT] = st_reg.brownout;
                    cfg[CFG_SECKEEP_BIT] = st_reg.seckeep;
                    tmp = merge(cfg, wb_dat_i, wmask);
                    st_next.src = tmp[CFG_SRC_LSB +: 2];
                    st_next.post = tmp[CFG_POST_BIT];
                    st_next.pbdiv = tmp[CFG_PBDIV_LSB +: 2];
                    st_next.sleep_sel = tmp[CFG_SLEEP_BIT];
                    st_next.startup = tmp[CFG_STARTUP_BIT];
                    st_next.failmon = tmp[CFG_FAILMON_BIT];
                    st_next.brownout = tmp[CFG_BROWNOUT_BIT];
                    st_next.seckeep = tmp[CFG_SECKEEP_BIT];
                end
                OFS_CMD:
                begin
                    // watchdog clear only on software request
                    st_next.wdclr = wmask[CMD_WDCLR_BIT] & wb_dat_i[CMD_WDCLR_BIT];
                end
                OFS_PDIS:
                begin
                    tmp = merge(32'(st_reg.pdis), wb_dat_i, wmask);
                    st_next.pdis = tmp[NP-1:0];
                end
                OFS_WAKE_EN:
                begin
                    tmp = merge(32'(st_reg.wake_en), wb_dat_i, wmask);
                    st_next.wake_en = tmp[NW-1:0];
                end
                OFS_WAKE_FLG:
                begin
                    // write one to clear
                    tmp = wb_dat_i & wmask;
                    st_next.wake_flg = st_reg.wake_flg & ~tmp[NW-1:0];
                end
                default:
                begin
                    // unmapped or read-only: write ignored, still acked
                end
            endcase
        end
        // a wake event in the clearing cycle stays recorded
        st_next.wake_flg = st_next.wake_flg | (wake_i & st_reg.wake_en);

        // read data, captured as the request is seen
        if (req && !st_reg.ack)
        begin
            tmp = '0;
            unique case (wb_adr_i)
                OFS_CFG:
                begin
                    tmp[CFG_SRC_LSB +: 2] = st_reg.src;
                    tmp[CFG_POST_BIT] = st_reg.post;
                    tmp[CFG_PBDIV_LSB +: 2] = st_reg.pbdiv;
                    tmp[CFG_SLEEP_BIT] = st_reg.sleep_sel;
                    tmp[CFG_STARTUP_BIT] = st_reg.startup;
                    tmp[CFG_FAILMON_BIT] = st_reg.failmon;
                    tmp[CFG_BROWNOUT_BIT] = st_reg.brownout;
                    tmp[CFG_SECKEEP_BIT] = st_reg.seckeep;
                end
                OFS_STAT:
                begin
                    tmp[STAT_MODE_LSB +: 4] = st_reg.mode;
                    tmp[STAT_SRC_LSB +: 2] = st_reg.src;
                end
                OFS_PDIS: tmp[NP-1:0] = st_reg.pdis;
                OFS_WAKE_EN: tmp[NW-1:0] = st_reg.wake_en;
                OFS_WAKE_FLG: tmp[NW-1:0] = st_reg.wake_flg;
                default: tmp = '0; // command and unmapped read zero
            endcase
            st_next.dat = tmp;
        end

        // mode sequencing; the cpu only leaves run by asking
        unique case (st_reg.mode)
            MODE_RUN:
            begin
                if (wait_req)
                begin
                    // mode select chosen beforehand decides the target
                    st_next.mode = st_reg.sleep_sel ? MODE_SLEEP : MODE_IDLE;
                end
            end
            MODE_IDLE:
            begin
                if (wake_hit)
                begin
                    st_next.mode = MODE_RUN;
                end
            end
            MODE_SLEEP:
            begin
                if (wake_hit)
                begin
                    // a source that never stopped needs no settling time
                    if (st_reg.startup && src_off)
                    begin
                        st_next.mode = MODE_WAKE;
                        st_next.cnt = start_cycles(st_reg.src);
                    end
                    else
                    begin
                        st_next.mode = MODE_RUN;
                    end
                end
            end
            MODE_WAKE:
            begin
                st_next.cnt = st_reg.cnt - 16'h0001;
                if (st_reg.cnt <= 16'h0001)
                begin
                    st_next.mode = MODE_RUN;
                end
            end
            default:
            begin
                st_next.mode = MODE_RUN; // illegal code recovers to run
            end
        endcase

        // output decode from the next mode so outputs align with it
        st_next.cpu_en = (st_next.mode == MODE_RUN);
        st_next.osc = 4'h0;
        st_next.osc[SRC_LOW_POWER_RC] = 1'b1;
        st_next.osc[SRC_SECONDARY] = st_next.seckeep;
        if (st_next.mode != MODE_SLEEP)
        begin
            // run, idle and wake keep the selected source going
            st_next.osc[st_next.src] = 1'b1;
        end
        if (st_next.mode == MODE_SLEEP || st_next.mode == MODE_WAKE)
        begin
            // only peripherals on their own clocks stay up
            st_next.pclk = ~st_next.pdis & SLEEP_KEEP;
        end
        else
        begin
            st_next.pclk = ~st_next.pdis;
        end
        st_next.fmon = st_next.failmon && st_next.mode != MODE_SLEEP
                       && st_next.mode != MODE_WAKE;
        st_next.hold = (st_next.mode == MODE_SLEEP || st_next.mode == MODE_WAKE);
    end

    // state register; reset picks fast rc, run mode, cpu and all peripheral clocks enabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
            st_reg.mode <= MODE_RUN;
            st_reg.src <= SRC_RST;
            st_reg.post <= BIT_RST;
            st_reg.pbdiv <= PBDIV_RST;
            st_reg.cpu_en <= 1'b1;
            st_reg.osc <= 4'h6;
            st_reg.pclk <= '1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // peripheral bus clock runs in run and idle only, and stops in sleep and wake whatever the source
    assign pb.ratio = st_reg.pbdiv;
    assign pb.run = (st_next.mode == MODE_RUN) || (st_next.mode == MODE_IDLE);

    pmc_pbdiv #(
        .CW(3)
    ) u_pbdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pb(pb.gen)
    );

    // outputs, all from flip-flops except idle and sleep, which are decoded from the mode register
    assign wb_dat_o = st_reg.dat;
    assign wb_ack_o = st_reg.ack;
    assign cpu_clk_en_o = st_reg.cpu_en;
    assign osc_en_o = st_reg.osc;
    assign system_clock_src_o = st_reg.src;
    assign fast_rc_oscillator_post_o = st_reg.post;
    assign peripheral_bus_clock_tick_o = pb.tick;
    assign periph_clk_en_o = st_reg.pclk;
    assign clock_failure_monitor_en_o = st_reg.fmon;
    // brownout follows its enable alone, sleep does not touch it
    assign brownout_reset_circuit_en_o = st_reg.brownout;
    // no pulse on sleep entry; the watchdog keeps its count
    assign watchdog_timer_clear_o = st_reg.wdclr;
    assign pin_hold_o = st_reg.hold;
    assign idle_o = (st_reg.mode == MODE_IDLE);
    assign sleep_o = (st_reg.mode == MODE_SLEEP);
endmodule

//--- testbench/pmc_top_checker.sv
// pmc_top_checker: concurrent checks on the ports of pmc_top.
// assumes one clock domain, clk_i, with synchronous active-high rst_i.
`timescale 1ns/100ps
module pmc_top_checker
#(
    parameter int unsigned NP = 8,
    parameter int unsigned NW = 8,
    parameter logic [NP-1:0] SLEEP_KEEP = 8'h0f
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_ack_o,
    input wire logic wait_i,
    input wire logic [NW-1:0] wake_i,
    input wire logic cpu_clk_en_o,
    input wire logic [3:0] osc_en_o,
    input wire logic [1:0] system_clock_src_o,
    input wire logic peripheral_bus_clock_tick_o,
    input wire logic [NP-1:0] periph_clk_en_o,
    input wire logic clock_failure_monitor_en_o,
    input wire logic brownout_reset_circuit_en_o,
    input wire logic watchdog_timer_clear_o,
    input wire logic pin_hold_o,
    input wire logic idle_o,
    input wire logic sleep_o
);
    // bound on any wake-up wait; covers the shortened start-up counts
    localparam int WAKE_MAX = 300;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // cpu running and asking to wait
    sequence s_run_wait;
        cpu_clk_en_o && wait_i;
    endsequence
    // either halted mode
    sequence s_halted;
        idle_o || sleep_o;
    endsequence
    property p_wait_enter;
        s_run_wait |=> (idle_o || sleep_o) && !cpu_clk_en_o;
    endproperty
    a_wait_enter: assert property (p_wait_enter) else $error("wait did not halt the cpu");
    property p_halt_gate;
        s_halted |-> !cpu_clk_en_o;
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("cpu clock on while halted");
    property p_osc_idle;
        idle_o |-> osc_en_o[system_clock_src_o];
    endproperty
    a_osc_idle: assert property (p_osc_idle) else $error("selected oscillator off in idle");
    property p_sleep_off;
        sleep_o |-> (periph_clk_en_o & ~SLEEP_KEEP) == '0 && !peripheral_bus_clock_tick_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("dependent clock alive in sleep");
    property p_failmon;
        sleep_o |-> !clock_failure_monitor_en_o;
    endproperty
    a_failmon: assert property (p_failmon) else $error("failure monitor on in sleep");
    property p_brownout;
        $rose(sleep_o) |-> brownout_reset_circuit_en_o == $past(brownout_reset_circuit_en_o);
    endproperty
    a_brownout: assert property (p_brownout) else $error("brownout enable moved on sleep");
    property p_no_wdclr;
        sleep_o |-> !watchdog_timer_clear_o;
    endproperty
    a_no_wdclr: assert property (p_no_wdclr) else $error("watchdog cleared in sleep");
    property p_pins;
        sleep_o |-> pin_hold_o;
    endproperty
    a_pins: assert property (p_pins) else $error("pins not held in sleep");
    property p_self;
        $rose(idle_o || sleep_o) |-> $past(wait_i) || $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_self: assert property (p_self) else $error("halt without a request");
    property p_idle_wake;
        $fell(idle_o) |-> cpu_clk_en_o && $past(|wake_i);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle left without wake");
    property p_wake_bound;
        $fell(sleep_o) |-> ##[0:WAKE_MAX] cpu_clk_en_o;
    endproperty
    a_wake_bound: assert property (p_wake_bound) else $error("cpu not resumed after sleep");
endmodule
bind pmc_top pmc_top_checker #(.NP(NP), .NW(NW), .SLEEP_KEEP(SLEEP_KEEP)) chk_u (.clk_i, .rst_i,
    .wb_ack_o, .wait_i, .wake_i, .cpu_clk_en_o, .osc_en_o, .system_clock_src_o,
    .peripheral_bus_clock_tick_o, .periph_clk_en_o, .clock_failure_monitor_en_o,
    .brownout_reset_circuit_en_o, .watchdog_timer_clear_o, .pin_hold_o, .idle_o, .sleep_o);

//--- testbench/pmc_far_model.sv
// pmc_far_model: a peripheral on its own clock that raises wake source 0
// after dly_i halted cycles once armed; assumes halted_i is !cpu_clk_en.
`timescale 1ns/100ps
module pmc_far_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic halted_i,
    input wire logic go_i,
    input wire logic [3:0] dly_i,
    output logic [7:0] wake_o
);
    logic [3:0] cnt_reg; // halted cycles left before waking
    logic armed_reg; // one wake per arming
    // keeps counting only while halted, as an own-clocked peripheral would
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            armed_reg <= 1'b0;
        else if (go_i || (!halted_i && cnt_reg == 4'h0))
            armed_reg <= go_i;
        if (go_i)
            cnt_reg <= dly_i;
        else if (armed_reg && halted_i && cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end
    // level wake, held until the cpu clock returns
    assign wake_o = {7'h00, armed_reg && halted_i && cnt_reg == 4'h0};
endmodule

//--- testbench/test_power_mode_clock_gating.sv
// test_power_mode_clock_gating: scenarios for pmc_top over wishbone.
// assumes a 10 MHz clock and shortened start-up counts.
`timescale 1ns/100ps
module test_power_mode_clock_gating;
    import pmc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic wait_i = 1'b0, go = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, wake_i, periph_clk_en_o;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [3:0] dly = 4'h0, osc_en_o;
    logic [1:0] system_clock_src_o;
    logic wb_ack_o, cpu_clk_en_o, fast_rc_oscillator_post_o, peripheral_bus_clock_tick_o, pin_hold_o;
    logic clock_failure_monitor_en_o, brownout_reset_circuit_en_o, watchdog_timer_clear_o, idle_o, sleep_o;
    int failures = 0, n_tests = 0, n, c;
    pmc_top #(.START_PRI(8), .START_FRC(10), .START_LOW_POWER_RC_OSCILLATOR(6), .START_SEC(12)) dut_u (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .wait_i, .wake_i, .cpu_clk_en_o, .osc_en_o, .system_clock_src_o, .fast_rc_oscillator_post_o,
        .peripheral_bus_clock_tick_o, .periph_clk_en_o, .clock_failure_monitor_en_o,
        .brownout_reset_circuit_en_o, .watchdog_timer_clear_o, .pin_hold_o, .idle_o, .sleep_o);
    pmc_far_model far_u (.clk_i, .rst_i, .halted_i(!cpu_clk_en_o), .go_i(go), .dly_i(dly), .wake_o(wake_i));
    // free-running bus clock, 100 ns period
    always #50 clk_i = ~clk_i;
    // compare one value and count it
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // one classic cycle; holds the request until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // count peripheral bus ticks over k cycles
    task ticks(input int k);
        c = 0;
        repeat (k)
        begin
            @(posedge clk_i);
            if (peripheral_bus_clock_tick_o === 1'b1)
                c++;
        end
    endtask
    // arm the far-side wake and pulse a cpu wait
    task halt(input logic [3:0] d);
        @(posedge clk_i);
        go <= 1'b1;
        dly <= d;
        wait_i <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        wait_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task t_reset;
        chk("cpu_en", 1, cpu_clk_en_o);
        chk("osc_en", 4'h6, osc_en_o);
        chk("pclk_en", 8'hff, periph_clk_en_o);
        wb(1'b0, OFS_CFG, 0);
        chk("cfg", {30'h0, SRC_RST}, rdat);
        wb(1'b0, 8'h3c, 0);
        chk("unmapped", 0, rdat);
        $display("test reset done");
    endtask
    // every source, postscaler on
    task t_src;
        for (int s = 0; s < 4; s++)
        begin
            wb(1'b1, OFS_CFG, s | 32'h4);
            wb(1'b0, OFS_STAT, 0);
            chk("src", s, system_clock_src_o);
            chk("osc_sel", 1, osc_en_o[s]);
            chk("post", 1, fast_rc_oscillator_post_o);
            chk("stat_src", s, rdat[5:4]);
        end
        $display("test sources done");
    endtask
    // divide by 4: one tick every 4 cycles
    task t_pbdiv;
        wb(1'b1, OFS_CFG, 32'h21);
        repeat (4) @(posedge clk_i);
        ticks(32);
        chk("ticks", 8, c);
        $display("test divider done");
    endtask
    task t_idle;
        wb(1'b1, OFS_PDIS, 1);
        wb(1'b1, OFS_WAKE_EN, 1);
        wb(1'b1, OFS_CFG, SRC_PRIMARY);
        halt(4'd8);
        chk("idle", 1, idle_o);
        chk("cpu_off", 0, cpu_clk_en_o);
        chk("pri_on", 1, osc_en_o[0]);
        chk("pclk_idle", 8'hfe, periph_clk_en_o);
        ticks(4);
        chk("idle_ticks", 4, c);
        repeat (10) @(posedge clk_i);
        chk("resumed", 1, cpu_clk_en_o);
        $display("test idle done");
    endtask
    task t_sleep;
        wb(1'b1, OFS_PDIS, 0);
        wb(1'b1, OFS_WAKE_FLG, 1);
        wb(1'b1, OFS_CFG, 32'hf00);
        wb(1'b1, OFS_CMD, 1);
        chk("failmon", 1, clock_failure_monitor_en_o);
        @(posedge clk_i);
        go <= 1'b1;
        dly <= 4'd5;
        @(posedge clk_i);
        go <= 1'b0;
        chk("sleep", 1, sleep_o);
        chk("failmon_off", 0, clock_failure_monitor_en_o);
        chk("brownout", 1, brownout_reset_circuit_en_o);
        chk("hold", 1, pin_hold_o);
        chk("wdclr", 0, watchdog_timer_clear_o);
        chk("pclk_sleep", 8'h0f, periph_clk_en_o);
        chk("pri_off", 0, osc_en_o[0]);
        ticks(2);
        chk("sleep_ticks", 0, c);
        while (wake_i[0] !== 1'b1)
            @(posedge clk_i);
        n = 0;
        while (cpu_clk_en_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("startup", 1, n >= 8 && n <= 10);
        wb(1'b0, OFS_WAKE_FLG, 0);
        chk("wake_flag", 1, rdat[0]);
        wb(1'b1, OFS_WAKE_FLG, 1);
        wb(1'b0, OFS_WAKE_FLG, 0);
        chk("flag_clr", 0, rdat[0]);
        $display("test sleep done");
    endtask
    task t_wdclr;
        wb(1'b1, OFS_CMD, 2);
        @(posedge clk_i);
        chk("wdclr_hi", 1, watchdog_timer_clear_o);
        @(posedge clk_i);
        chk("wdclr_lo", 0, watchdog_timer_clear_o);
        $display("test watchdog clear done");
    endtask
    // print counts and the verdict, then end the run
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge clk_i);
        failures++;
        $display("[FAIL] watchdog exp done got hang");
        stop_test;
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_src;
        t_pbdiv;
        t_idle;
        t_sleep;
        t_wdclr;
        stop_test;
    end
endmodule
